//--- logic/ovm_pkg.sv
/*
 * ovm_pkg: register map, field layout, reset values and timing constants
 * of the overrange flag and sample marking block.
 * Assumes a 32-bit plain register port with word index addresses.
 */
`default_nettype none
package ovm_pkg;
   localparam int unsigned SAMPLE_W = 12;
   localparam int unsigned THR_W = 8;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned CNT_W = 10;
   localparam int unsigned LEN_W = 11;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NFLAG = 4;

   // register indexes on the plain port
   localparam logic [7:0] REG_OVR_CFG = 8'h00;
   localparam logic [7:0] REG_MARK_CTRL = 8'h01;
   localparam logic [7:0] REG_CLK_CTRL2 = 8'h02;
   localparam logic [7:0] REG_FLAG_STAT = 8'h03;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h05;

   // field positions in the overrange config, mark control and clock control words
   localparam int unsigned F_T0_LSB = 0;
   localparam int unsigned F_T1_LSB = 8;
   localparam int unsigned F_SEL_LSB = 16;
   localparam int unsigned F_MARK_EN = 0;
   localparam int unsigned F_SYSREF_SEL = 0;

   // reset values
   localparam logic [7:0] RST_T0 = 8'hFF;
   localparam logic [7:0] RST_T1 = 8'hFF;
   localparam logic [2:0] RST_SEL = 3'h0;

   // shortest flag hold, in device clock cycles
   localparam logic [10:0] HOLD_BASE = 11'h008;
   // most negative two's complement code and saturated magnitude
   localparam logic [11:0] CODE_MIN = 12'h800;
   localparam logic [10:0] MAG_MAX = 11'h7FF;
   // clock period in ns, for reference of hold lengths
   localparam real CLK_PERIOD_NS = 5.0;

   typedef struct packed {
      logic [2:0] hold_sel;
      logic [7:0] low_thr;
      logic [7:0] high_thr;
   } ovm_cfg_s;

   typedef struct packed {
      logic valid;
      logic [11:0] a;
      logic [11:0] b;
      logic mark;
   } ovm_smp_s;
endpackage : ovm_pkg
`default_nettype wire

//--- logic/ovm_overrange_mark.sv
/*
 * ovm_overrange_mark: overrange threshold flags with stretched hold, dither
 * removal, event mark insertion and a small register file with interrupt.
 * Assumes samples arrive in two's complement on ref_clk with their dither,
 * and that the marker pins are asynchronous to ref_clk.
 */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ovm_overrange_mark (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ovm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ovm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ovm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [ovm_pkg::SAMPLE_W-1:0] chan_a_sample,
   input wire logic [ovm_pkg::SAMPLE_W-1:0] chan_b_sample,
   input wire logic [ovm_pkg::SAMPLE_W-1:0] chan_a_dither,
   input wire logic [ovm_pkg::SAMPLE_W-1:0] chan_b_dither,
   input wire logic event_mark_input,
   input wire logic sysref_input,
   output logic out_valid,
   output logic [ovm_pkg::SAMPLE_W-1:0] chan_a_out,
   output logic [ovm_pkg::SAMPLE_W-1:0] chan_b_out,
   output logic chan_a_flag_high,
   output logic chan_a_flag_low,
   output logic chan_b_flag_high,
   output logic chan_b_flag_low,
   output logic irq
);

   // saturating magnitude of a two's complement code, top eight bits
   function automatic logic [7:0] mag_top(input logic [11:0] code);
      logic [10:0] mag;
      mag = 11'h000;
      if (code == ovm_pkg::CODE_MIN) begin
         mag = ovm_pkg::MAG_MAX;
      end else if (code[11]) begin
         mag = 11'(-code);
      end else begin
         mag = code[10:0];
      end
      return mag[10:3];
   endfunction : mag_top

   // hold length in cycles: base shifted by the select
   function automatic logic [10:0] hold_len(input logic [2:0] sel);
      return ovm_pkg::HOLD_BASE << sel;
   endfunction : hold_len

   // saturating removal of dither
   function automatic logic [11:0] undither(input logic [11:0] s,
                                            input logic [11:0] d);
      logic [12:0] diff;
      diff = {s[11], s} - {d[11], d};
      // clip rather than wrap: a wrapped code would trip the wrong flag
      if (diff[12] != diff[11]) begin
         return diff[12] ? ovm_pkg::CODE_MIN : {1'b0, ovm_pkg::MAG_MAX};
      end
      return diff[11:0];
   endfunction : undither

   ovm_pkg::ovm_cfg_s cfg_r;
   logic mark_en_r;
   logic sysref_sel_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_mask_r;
   logic [31:0] rdata_r;
   logic [2:0] tm_sync_r;
   logic [2:0] sr_sync_r;
   logic tm_lvl_r;
   logic sr_lvl_r;
   ovm_pkg::ovm_smp_s s1_r;
   logic s1_en_r;
   logic [3:0] flag_r;
   logic [3:0] flag_d_r;

   // address decode on the plain port
   wire wr_cfg = reg_wr && (reg_addr == ovm_pkg::REG_OVR_CFG);
   wire wr_mark = reg_wr && (reg_addr == ovm_pkg::REG_MARK_CTRL);
   wire wr_clk2 = reg_wr && (reg_addr == ovm_pkg::REG_CLK_CTRL2);
   wire wr_istat = reg_wr && (reg_addr == ovm_pkg::REG_IRQ_STAT);
   wire wr_imask = reg_wr && (reg_addr == ovm_pkg::REG_IRQ_MASK);

   // config registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= '{hold_sel: ovm_pkg::RST_SEL, low_thr: ovm_pkg::RST_T1,
                    high_thr: ovm_pkg::RST_T0};
         mark_en_r <= 1'b0;
         sysref_sel_r <= 1'b0;
         irq_mask_r <= 4'h0;
      end else begin
         if (wr_cfg) begin
            cfg_r.high_thr <= reg_wdata[ovm_pkg::F_T0_LSB +: 8];
            cfg_r.low_thr <= reg_wdata[ovm_pkg::F_T1_LSB +: 8];
            cfg_r.hold_sel <= reg_wdata[ovm_pkg::F_SEL_LSB +: 3];
         end
         if (wr_mark) begin
            mark_en_r <= reg_wdata[ovm_pkg::F_MARK_EN];
         end
         if (wr_clk2) begin
            sysref_sel_r <= reg_wdata[ovm_pkg::F_SYSREF_SEL];
         end
         if (wr_imask) begin
            irq_mask_r <= reg_wdata[3:0];
         end
      end
   end

   // read mux; unmapped indexes read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         ovm_pkg::REG_OVR_CFG: rd_mux = {13'h0000, cfg_r};
         ovm_pkg::REG_MARK_CTRL: rd_mux = {31'h0000_0000, mark_en_r};
         ovm_pkg::REG_CLK_CTRL2: rd_mux = {31'h0000_0000, sysref_sel_r};
         ovm_pkg::REG_FLAG_STAT: rd_mux = {28'h000_0000, flag_r};
         ovm_pkg::REG_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_r};
         ovm_pkg::REG_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_r;

   // marker pins: three flops, level accepted once stages two and three agree
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tm_sync_r <= 3'h0;
         sr_sync_r <= 3'h0;
         tm_lvl_r <= 1'b0;
         sr_lvl_r <= 1'b0;
      end else begin
         // stage one feeds only the shift, never any decision
         tm_sync_r <= {tm_sync_r[1:0], event_mark_input};
         sr_sync_r <= {sr_sync_r[1:0], sysref_input};
         if (tm_sync_r[1] == tm_sync_r[2]) begin
            tm_lvl_r <= tm_sync_r[2];
         end
         if (sr_sync_r[1] == sr_sync_r[2]) begin
            sr_lvl_r <= sr_sync_r[2];
         end
      end
   end

   // marker source; the sync adds a fixed lag versus the pin
   wire mark_src = sysref_sel_r ? sr_lvl_r : tm_lvl_r;

   // stage one: dither removed, marker captured beside the same sample
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s1_en_r <= 1'b0;
      end else begin
         s1_r.valid <= sample_valid;
         s1_r.a <= undither(chan_a_sample, chan_a_dither);
         s1_r.b <= undither(chan_b_sample, chan_b_dither);
         s1_r.mark <= mark_src;
         s1_en_r <= mark_en_r;
      end
   end

   // stage two: output words, marker kept at the data latency
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         chan_a_out <= 12'h000;
         chan_b_out <= 12'h000;
      end else begin
         out_valid <= s1_r.valid;
         if (s1_en_r) begin
            chan_a_out <= {s1_r.a[11:1], s1_r.mark};
            chan_b_out <= {s1_r.b[11:1], s1_r.mark};
         end else begin
            chan_a_out <= s1_r.a;
            chan_b_out <= s1_r.b;
         end
      end
   end

   // magnitudes, shared thresholds for both channels
   wire [7:0] mag_a = mag_top(s1_r.a);
   wire [7:0] mag_b = mag_top(s1_r.b);
   wire [10:0] len = hold_len(cfg_r.hold_sel);
   wire [9:0] len_m1 = 10'(len - 11'h001);
   wire [3:0] ev;
   logic [9:0] cnt_r [4];

   // flag i: bit0 picks low threshold, bit1 picks channel b
   // four identical lanes, each with its own hold counter
   for (genvar g = 0; g < ovm_pkg::NFLAG; g++) begin : g_flag
      wire [7:0] thr = g[0] ? cfg_r.low_thr : cfg_r.high_thr;
      wire [7:0] mag = g[1] ? mag_b : mag_a;
      assign ev[g] = s1_r.valid && (mag >= thr);

      // hold counter restarts on every event while the flag stands
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            cnt_r[g] <= 10'h000;
            flag_r[g] <= 1'b0;
         end else if (ev[g]) begin
            cnt_r[g] <= len_m1;
            flag_r[g] <= 1'b1;
         end else if (cnt_r[g] != 10'h000) begin
            cnt_r[g] <= cnt_r[g] - 10'h001;
         end else begin
            flag_r[g] <= 1'b0;
         end
      end

      // each event reloads the hold, so the flag rises and counts afresh
      a_flag_on_event: assert property (@(posedge ref_clk)
         disable iff (!nrst) ev[g] |=> flag_r[g])
         else $error("flag not set after event");
      a_hold_restart: assert property (@(posedge ref_clk)
         disable iff (!nrst) ev[g] |=> cnt_r[g] == $past(len_m1))
         else $error("hold counter not reloaded");
      // shortest hold: eight quiet cycles after the event, then release
      a_flag_hold_len: assert property (@(posedge ref_clk)
         disable iff (!nrst)
         (ev[g] && cfg_r.hold_sel == 3'h0) ##1 (!ev[g]) [*8]
         |-> flag_r[g] ##1 !flag_r[g])
         else $error("flag hold length wrong");
      a_flag_no_event: assert property (@(posedge ref_clk)
         disable iff (!nrst) !flag_r[g] |-> cnt_r[g] == 10'h000)
         else $error("flag low with hold pending");
      a_flag_release: assert property (@(posedge ref_clk)
         disable iff (!nrst)
         $fell(flag_r[g]) |-> $past(cnt_r[g]) == 10'h000 && !$past(ev[g]))
         else $error("flag dropped before hold ran out");
      a_flag_stays: assert property (@(posedge ref_clk)
         disable iff (!nrst) (cnt_r[g] != 10'h000) |=> flag_r[g])
         else $error("flag dropped while hold counting");
   end

   assign chan_a_flag_high = flag_r[0];
   assign chan_a_flag_low = flag_r[1];
   assign chan_b_flag_high = flag_r[2];
   assign chan_b_flag_low = flag_r[3];

   // sticky status on flag rise; set wins over a clear in the same cycle
   wire [3:0] flag_rise = flag_r & ~flag_d_r;
   wire [3:0] clr = wr_istat ? reg_wdata[3:0] : 4'h0;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flag_d_r <= 4'h0;
         irq_stat_r <= 4'h0;
      end else begin
         flag_d_r <= flag_r;
         irq_stat_r <= (irq_stat_r & ~clr) | flag_rise;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // datapath checks
   a_mag_saturate: assert property (@(posedge ref_clk)
      disable iff (!nrst) (s1_r.a == ovm_pkg::CODE_MIN) |-> mag_a == 8'hFF)
      else $error("most negative code not saturated");
   a_mag_negative: assert property (@(posedge ref_clk)
      disable iff (!nrst) (s1_r.b == 12'h810) |-> mag_b == 8'hFE)
      else $error("negative magnitude wrong");
   a_shared_thr: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (mag_a == mag_b) |-> (ev[0] == ev[2]) && (ev[1] == ev[3]))
      else $error("channels use different thresholds");
   a_dither_removed: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      1'b1 |=> s1_r.a == undither($past(chan_a_sample),
                                  $past(chan_a_dither)))
      else $error("dither not removed");
   // output word two edges after the sample, marker on the same edge
   a_out_latency: assert property (@(posedge ref_clk)
      disable iff (!nrst) sample_valid |-> ##2 out_valid)
      else $error("output word latency wrong");
   a_mark_inserted: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (mark_en_r && !wr_mark) ##1 1'b1 |=>
      chan_a_out == {$past(s1_r.a[11:1]), $past(s1_r.mark)})
      else $error("marker not in lsb");
   a_mark_chan_b: assert property (@(posedge ref_clk)
      disable iff (!nrst) s1_en_r |=> chan_b_out[0] == $past(s1_r.mark))
      else $error("marker missing on channel b");
   a_mark_bypass: assert property (@(posedge ref_clk)
      disable iff (!nrst) !s1_en_r |=> chan_b_out == $past(s1_r.b))
      else $error("sample altered while marking off");
   a_mark_source: assert property (@(posedge ref_clk)
      disable iff (!nrst) sysref_sel_r |=> s1_r.mark == $past(sr_lvl_r))
      else $error("sysref not used as marker");
   a_sync_level: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (tm_sync_r[2] == tm_sync_r[1]) |=> tm_lvl_r == $past(tm_sync_r[2]))
      else $error("marker level not accepted");
   // a rise is never lost to a clear written in the same cycle
   a_stat_set_wins: assert property (@(posedge ref_clk)
      disable iff (!nrst) (flag_rise != 4'h0) |=>
      (irq_stat_r & $past(flag_rise)) == $past(flag_rise))
      else $error("status rise lost");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
      ((irq_mask_r & flag_rise) != 4'h0) && !wr_imask |=> irq)
      else $error("interrupt missing");
   a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");

   c_high_trip: cover property (@(posedge ref_clk) disable iff (!nrst)
      $rose(chan_a_flag_high));
   c_restart: cover property (@(posedge ref_clk) disable iff (!nrst)
      flag_r[1] && ev[1]);
   c_marked: cover property (@(posedge ref_clk) disable iff (!nrst)
      s1_en_r && s1_r.mark && s1_r.valid);
   c_sysref_mark: cover property (@(posedge ref_clk) disable iff (!nrst)
      sysref_sel_r && s1_en_r && s1_r.mark);
   c_irq_raise: cover property (@(posedge ref_clk) disable iff (!nrst)
      $rose(irq));

endmodule : ovm_overrange_mark
`default_nettype wire

//--- sim/ovm_sink.sv
/*
 * ovm_sink: downstream logic device watching the four flag outputs.
 * Assumes the flags are registered on ref_clk and active high.
 */
`timescale 1ns/100ps
`default_nettype none
module ovm_sink (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic chan_a_flag_high,
   input wire logic chan_a_flag_low,
   input wire logic chan_b_flag_high,
   input wire logic chan_b_flag_low,
   output logic over_high,
   output logic over_low,
   output logic quiet_long
);
   logic [15:0] quiet_r;
   logic [15:0] quiet_nxt;

   // single-channel view: channel flags of one threshold merged
   assign over_high = chan_a_flag_high | chan_b_flag_high;
   assign over_low = chan_a_flag_low | chan_b_flag_low;
   // saturating count, so a weak signal never wraps back to busy
   assign quiet_nxt = (quiet_r == 16'hFFFF) ? quiet_r : quiet_r + 16'h0001;
   assign quiet_long = &quiet_r[15:12];

   // quiet time of the low flag, a cue to raise gain
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         quiet_r <= 16'h0000;
      end else begin
         quiet_r <= over_low ? 16'h0000 : quiet_nxt;
      end
   end
endmodule : ovm_sink
`default_nettype wire

//--- sim/tb_top.sv
/*
 * tb_top: directed scenarios for the overrange flag and marking block.
 * Assumes the sink model watches the flags as the downstream device.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic sample_valid = 1'b0;
   logic [11:0] a_in = 12'h000;
   logic [11:0] b_in = 12'h000;
   logic [11:0] a_dith = 12'h000;
   logic [11:0] b_dith = 12'h000;
   logic mark_pin = 1'b0;
   logic sysref = 1'b0;
   logic out_valid, irq, fah, fal, fbh, fbl, over_high, over_low, quiet;
   logic [11:0] a_out, b_out;
   int fail_count = 0;
   int n_checks = 0;

   // 2.5 ns half period, 200 MHz
   always #2.5 ref_clk = ~ref_clk;

   ovm_overrange_mark DUT (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .chan_a_sample(a_in), .chan_b_sample(b_in), .chan_a_dither(a_dith),
      .chan_b_dither(b_dith), .event_mark_input(mark_pin),
      .sysref_input(sysref), .out_valid(out_valid), .chan_a_out(a_out),
      .chan_b_out(b_out), .chan_a_flag_high(fah), .chan_a_flag_low(fal),
      .chan_b_flag_high(fbh), .chan_b_flag_low(fbl), .irq(irq));
   ovm_sink sink (.ref_clk(ref_clk), .nrst(nrst), .chan_a_flag_high(fah),
      .chan_a_flag_low(fal), .chan_b_flag_high(fbh), .chan_b_flag_low(fbl),
      .over_high(over_high), .over_low(over_low), .quiet_long(quiet));

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one-cycle strobes, changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // one valid sample, returns in the cycle its output word stands
   task automatic push(input logic [11:0] a, input logic [11:0] b);
      int i;
      @(posedge ref_clk);
      a_in <= a;
      b_in <= b;
      sample_valid <= 1'b1;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      #1;
      for (i = 0; i < 8 && out_valid !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("out_valid", 1'b1, out_valid);
   endtask : push

   task automatic t_regs;
      logic [31:0] d;
      int k;
      rd(ovm_pkg::REG_OVR_CFG, d);
      chk("cfg reset", 32'h0000_FFFF, d);
      for (k = 1; k < 6; k++) begin
         rd(k[7:0], d);
         chk("reg reset", 32'h0, d);
      end
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, d);
      chk("unmapped", 32'h0, d);
      wr(ovm_pkg::REG_FLAG_STAT, 32'h0000_000F);
      rd(ovm_pkg::REG_FLAG_STAT, d);
      chk("flags read only", 32'h0, d);
      wr(ovm_pkg::REG_OVR_CFG, 32'hFFFF_FFFF);
      rd(ovm_pkg::REG_OVR_CFG, d);
      chk("cfg fields", 32'h0007_FFFF, d);
   endtask : t_regs

   // magnitudes around both thresholds, channel b gets the negation
   task automatic t_thresh;
      logic [11:0] s [6] = '{12'h7F0, 12'h800, 12'h720, 12'h71F, 12'h200,
                             12'h1FF};
      logic [1:0] e [6] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0};
      int k;
      wr(ovm_pkg::REG_OVR_CFG, {13'h0, 3'h0, 8'h40, 8'hE4});
      for (k = 0; k < 6; k++) begin
         push(s[k], -s[k]);
         chk("a flags", e[k], {fah, fal});
         chk("b flags", e[k], {fbh, fbl});
         chk("or high", e[k][1], over_high);
         chk("or low", e[k][0], over_low);
         repeat (12) @(posedge ref_clk);
      end
   endtask : t_thresh

   task automatic t_irq;
      logic [31:0] d;
      rd(ovm_pkg::REG_IRQ_STAT, d);
      chk("irq stat", 32'h0000_000F, d);
      chk("irq masked", 1'b0, irq);
      wr(ovm_pkg::REG_IRQ_MASK, 32'h0000_0002);
      #1 chk("irq on", 1'b1, irq);
      wr(ovm_pkg::REG_IRQ_STAT, 32'h0000_0002);
      #1 chk("irq cleared", 1'b0, irq);
      rd(ovm_pkg::REG_IRQ_STAT, d);
      chk("irq w1c", 32'h0000_000D, d);
   endtask : t_irq

   // counts cycles the high flag of channel a stands
   task automatic hold_len(output int n);
      n = 0;
      while (fah === 1'b1 && n < 2000) begin
         n++;
         @(posedge ref_clk);
         #1;
      end
   endtask : hold_len

   task automatic t_hold;
      int sel, n;
      for (sel = 0; sel < 8; sel++) begin
         wr(ovm_pkg::REG_OVR_CFG, {13'h0, sel[2:0], 8'h40, 8'hE4});
         push(12'h7F0, 12'h000);
         hold_len(n);
         chk("hold length", 32'h8 << sel, n);
         repeat (4) @(posedge ref_clk);
      end
      wr(ovm_pkg::REG_OVR_CFG, {13'h0, 3'h0, 8'h40, 8'hE4});
      push(12'h7F0, 12'h000);
      repeat (2) @(posedge ref_clk);
      push(12'h7F0, 12'h000);
      hold_len(n);
      chk("hold restart", 32'h8, n);
   endtask : t_hold

   // marker pins settle well ahead: the synchroniser lags a few cycles
   task automatic t_mark;
      @(posedge ref_clk);
      a_dith <= 12'h003;
      b_dith <= 12'h001;
      mark_pin <= 1'b0;
      push(12'h106, 12'h106);
      chk("plain a", 12'h103, a_out);
      chk("plain b", 12'h105, b_out);
      wr(ovm_pkg::REG_MARK_CTRL, 32'h1);
      push(12'h106, 12'h106);
      chk("marked a", 12'h102, a_out);
      chk("marked b", 12'h104, b_out);
      @(posedge ref_clk);
      mark_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      push(12'h106, 12'h106);
      chk("pin mark a", 12'h103, a_out);
      chk("pin mark b", 12'h105, b_out);
      @(posedge ref_clk);
      mark_pin <= 1'b0;
      sysref <= 1'b1;
      wr(ovm_pkg::REG_CLK_CTRL2, 32'h1);
      repeat (6) @(posedge ref_clk);
      push(12'h106, 12'h106);
      chk("sysref a", 12'h103, a_out);
      chk("sysref b", 12'h105, b_out);
   endtask : t_mark

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // main sequence after four cycles of reset
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs;
      t_thresh;
      t_irq;
      t_hold;
      t_mark;
      close_out;
   end

   // watchdog, far beyond the roughly 2300 cycles the tests need
   initial begin
      #200000;
      fail_count++;
      close_out;
   end
endmodule : tb_top
`default_nettype wire
